// >>> dv/bmc_host.sv
// Host controller model that issues field-bus commands and re-powers the unit.
`timescale 1ns/10ps

module bmc_host
    import bmc_pkg::*;
(
    input wire logic clock,
    output logic power_cycle,
    output logic cmd_valid,
    output bmc_cmd_t cmd,
    input wire logic resp_valid,
    input bmc_resp_t resp
);
    initial begin
        power_cycle = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
    end

    task automatic send(input logic w, input logic [15:0] c, input logic [15:0] d);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd = '{w, c, d};
        @(negedge clock);
        cmd_valid = 1'b0;
        // Released bus never shows the last command
        cmd = ~cmd;
    endtask

    task automatic rd(input logic [15:0] c, output bmc_resp_t r);
        send(1'b0, c, 16'h0000);
        for (int i = 0; i < 4 && resp_valid !== 1'b1; i++) begin
            @(negedge clock);
        end
        r = resp;
    endtask

    task automatic repower();
        @(negedge clock);
        power_cycle = 1'b1;
        @(negedge clock);
        power_cycle = 1'b0;
    endtask

    // Bit 0 clear hands direction to the pin
    task automatic enter_battery(input logic bus_dir);
        send(1'b1, CODE_SYS_CFG, {14'h0000, 1'b1, bus_dir});
        send(1'b1, CODE_DIR_MODE, DIR_MODE_BATTERY);
    endtask
endmodule

// >>> dv/testbench.sv
// Self-checking testbench for the bidirectional mode controller.
`timescale 1ns/10ps

module testbench
    import bmc_pkg::*;
;
    logic clock, rstn, power_cycle, cmd_valid, resp_valid, cd_pin, remote_pin;
    logic battery_mode, dir_discharge, current_limited, conv_enable, fault_out;
    logic master, parallel_ok, green_led;
    logic [2:0] addr_sw_pin;
    logic [3:0] unit_count;
    logic [15:0] target_voltage, dc_voltage, peer_max_voltage, voltage_target, current_target;
    bmc_cmd_t cmd;
    bmc_resp_t resp, r;
    bmc_prot_t prot;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int blinks = 0;
    int b0;
    logic led_q = 1'b0;
    logic [15:0] codes[8] = '{CODE_OPERATION, CODE_CHG_V, CODE_CHG_I, CODE_DIS_V,
        CODE_DIS_I, CODE_SYS_CFG, CODE_DIR_CMD, CODE_DIR_MODE};
    logic [15:0] defs[8] = '{{8'h00, DEF_OPERATION}, DEF_CHG_V, DEF_CHG_I, DEF_DIS_V,
        DEF_DIS_I, DEF_SYS_CFG, {8'h00, DEF_DIR_CMD}, DEF_DIR_MODE};

    bmc_mode_ctrl #(.FAULT_LEAD_CYCLES(32'h14), .RESTORE_WINDOW_CYCLES(32'h4E20),
        .BLINK_HALF_CYCLES(32'h0A)) dut_u (.clock, .rstn, .power_cycle, .cmd_valid, .cmd,
        .resp_valid, .resp, .cd_pin, .remote_pin, .addr_sw_pin, .target_voltage,
        .dc_voltage, .prot, .peer_max_voltage, .unit_count, .battery_mode, .dir_discharge,
        .current_limited, .voltage_target, .current_target, .conv_enable, .fault_out,
        .master, .parallel_ok, .green_led);

    bmc_host host_u (.clock, .power_cycle, .cmd_valid, .cmd, .resp_valid, .resp);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic check_defaults();
        for (int i = 0; i < 8; i++) begin
            host_u.rd(codes[i], r);
            check(r.data, defs[i]);
        end
    endtask

    task automatic dir_case(input logic [7:0] dcmd, input logic [15:0] dcv,
        input logic [1:0] exp, input logic [15:0] exp_i);
        host_u.send(1'b1, CODE_DIR_CMD, {8'h00, dcmd});
        dc_voltage = dcv;
        cyc(3);
        check({14'h0000, dir_discharge, current_limited}, {14'h0000, exp});
        check(current_target, exp_i);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("ERROR at %0t: timeout", $time);
            summarize();
        end
    end

    // Counts rising edges of the green indicator
    always @(negedge clock) begin
        led_q <= green_led;
        if (green_led === 1'b1 && led_q === 1'b0) begin
            blinks <= blinks + 1;
        end
    end

    initial begin
        rstn = 1'b0;
        cd_pin = 1'b1;
        remote_pin = 1'b0;
        addr_sw_pin = 3'h7;
        target_voltage = 16'h1000;
        dc_voltage = 16'h0800;
        prot = '0;
        peer_max_voltage = 16'h0000;
        unit_count = 4'h9;
        cyc(10);
        rstn = 1'b1;
        check_defaults();
        host_u.rd(16'h0FFF, r);
        check({15'h0000, r.err}, 16'h0001);
        $display("test defaults done");
        check({15'h0000, battery_mode}, 16'h0000);
        check({15'h0000, dir_discharge}, 16'h0000);
        check({15'h0000, conv_enable}, 16'h0000);
        check({15'h0000, parallel_ok}, 16'h0001);
        host_u.send(1'b1, CODE_DIR_CMD, 16'h0001);
        cd_pin = 1'b0;
        remote_pin = 1'b1;
        cyc(2600);
        check({15'h0000, dir_discharge}, 16'h0000);
        check({15'h0000, conv_enable}, 16'h0001);
        cyc(3);
        check({15'h0000, master}, 16'h0001);
        peer_max_voltage = 16'hFFFF;
        cyc(3);
        check({15'h0000, master}, 16'h0000);
        peer_max_voltage = 16'h0000;
        dc_voltage = 16'h2000;
        cyc(3);
        check({15'h0000, dir_discharge}, 16'h0001);
        $display("test auto mode done");
        host_u.send(1'b1, CODE_CHG_I, 16'h0100);
        host_u.send(1'b1, CODE_DIS_I, 16'h0200);
        host_u.enter_battery(1'b1);
        cyc(3);
        check({15'h0000, battery_mode}, 16'h0000);
        host_u.repower();
        cyc(3);
        check({15'h0000, battery_mode}, 16'h0001);
        dir_case(8'h01, 16'h2000, 2'b10, 16'h0200);
        check(voltage_target, DEF_DIS_V);
        dir_case(8'h01, 16'h1000, 2'b01, LIMITED_CURRENT);
        dir_case(8'h00, 16'h2000, 2'b11, LIMITED_CURRENT);
        dir_case(8'h00, 16'h1000, 2'b00, 16'h0100);
        check(voltage_target, DEF_CHG_V);
        host_u.enter_battery(1'b0);
        dc_voltage = 16'h1300;
        cyc(3);
        check({15'h0000, dir_discharge}, 16'h0001);
        cd_pin = 1'b1;
        cyc(2600);
        check({15'h0000, dir_discharge}, 16'h0000);
        $display("test battery mode done");
        prot.overload_protection = 1'b1;
        cyc(1);
        check({14'h0000, fault_out, conv_enable}, 16'h0003);
        cyc(18);
        check({15'h0000, conv_enable}, 16'h0001);
        cyc(4);
        check({15'h0000, conv_enable}, 16'h0000);
        prot = '0;
        host_u.repower();
        cyc(3);
        check({15'h0000, fault_out}, 16'h0000);
        prot.grid_loss_event = 1'b1;
        cyc(1);
        check({15'h0000, fault_out}, 16'h0001);
        cyc(2);
        check({15'h0000, conv_enable}, 16'h0000);
        prot = '0;
        unit_count = 4'hA;
        cyc(2);
        check({15'h0000, parallel_ok}, 16'h0000);
        $display("test faults done");
        remote_pin = 1'b0;
        // Storage disabled: the first restore keeps the configuration word
        host_u.send(1'b1, CODE_SYS_CFG, 16'h0400);
        for (int i = 0; i < 2; i++) begin
            host_u.repower();
            cyc(5100);
            addr_sw_pin = 3'h0;
            cyc(2600);
            addr_sw_pin = 3'h7;
            b0 = blinks;
            cyc(2700);
            check(16'(blinks - b0), 16'h0003);
            host_u.rd(CODE_SYS_CFG, r);
            check(r.data, (i == 0) ? 16'h0400 : DEF_SYS_CFG);
        end
        check_defaults();
        $display("test restore done");
        summarize();
    end
endmodule

// >>> hw/bmc_mode_ctrl.sv
// Direction, fault timing, remote enable and factory restore for the bidirectional unit.
// Overview of operation
// - After reset the unit runs in auto-detect mode, choosing direction itself.
// - Auto mode: target above DC voltage selects charging.
// - Auto mode: target below DC voltage selects discharging.
// - Auto mode ignores the charge/discharge pin and the direction command.
// - Battery mode takes effect only after a power cycle following configuration.
// - Battery mode exists only with the field bus; bus or pin picks direction.
// - Direction command 00h charges, 01h discharges.
// - Charge setpoints give voltage and current targets while charging.
// - Discharge setpoints give voltage and current targets while discharging.
// - The pin steers direction only while configuration bit 0 is clear.
// - Charge request with battery above charge setpoint discharges at 5% current.
// - Discharge request with battery below discharge setpoint charges at 5% current.
// - Overload, short or over-temperature raise fault 100 ms before shutdown.
// - Other protections raise fault at the moment of shutdown.
// - Output enabled only while remote input is tied to auxiliary five volts.
// - Up to 9 units may share current in parallel.
// - The unit with the highest voltage is master and sets the bus.
// - Restore: start remote-off, switches on; within 15 s all off then on.
// - Restore returns all listed command parameters to defaults except the direction command.
// - Green indicator blinks 3 times after a restore.
// - With storage disabled the restore must be done twice.
// - Battery mode: pin high charges, pin low discharges.
`timescale 1ns/10ps

module bmc_mode_ctrl
    import bmc_pkg::*;
#(
    parameter bit HAS_FIELD_BUS = 1'b1,
    parameter logic [31:0] FAULT_LEAD_CYCLES = FAULT_LEAD_CYC,
    parameter logic [31:0] RESTORE_WINDOW_CYCLES = RESTORE_WINDOW_CYC,
    parameter logic [31:0] BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic power_cycle,
    input wire logic cmd_valid,
    input bmc_cmd_t cmd,
    output logic resp_valid,
    output bmc_resp_t resp,
    input wire logic cd_pin,
    input wire logic remote_pin,
    input wire logic [ADDR_BITS-1:0] addr_sw_pin,
    input wire logic [15:0] target_voltage,
    input wire logic [15:0] dc_voltage,
    input bmc_prot_t prot,
    input wire logic [15:0] peer_max_voltage,
    input wire logic [3:0] unit_count,
    output logic battery_mode,
    output logic dir_discharge,
    output logic current_limited,
    output logic [15:0] voltage_target,
    output logic [15:0] current_target,
    output logic conv_enable,
    output logic fault_out,
    output logic master,
    output logic parallel_ok,
    output logic green_led
);

    typedef enum logic [2:0] {RS_ARM, RS_WAIT_OFF, RS_WAIT_ON, RS_BLINK, RS_DONE} bmc_rs_t;

    logic [NUM_IN-1:0] raw_in, db;
    logic [7:0] operation, dir_cmd;
    logic [15:0] chg_v, chg_i, dis_v, dis_i, sys_cfg, dir_mode, next_vt, next_it;
    logic shutdown, lead_busy, restore_pulse, restore_pass, blink_led;
    logic req_dis, next_dir, next_lim, addr_all_on, addr_all_off, prot_lead;
    logic [31:0] lead_cnt, win_cnt, blink_cnt;
    logic [2:0] blink_edges;
    bmc_rs_t rs_state;
    bmc_resp_t next_resp;

    assign raw_in = {addr_sw_pin, remote_pin, cd_pin};
    assign addr_all_on = &db[IN_ADDR +: ADDR_BITS];
    assign addr_all_off = ~|db[IN_ADDR +: ADDR_BITS];
    assign prot_lead = prot.overload_protection | prot.short_circuit_protection
        | prot.over_temperature;

    // Two-stage synchroniser, then a level must hold for the debounce time
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_deb
            logic meta, sync, stable;
            logic [11:0] cnt;
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                    stable <= 1'b0;
                    cnt <= 12'h000;
                end else begin
                    meta <= raw_in[gi];
                    sync <= meta;
                    if (sync == stable) begin
                        cnt <= 12'h000;
                    end else if (cnt == DEBOUNCE_CYC - 12'h001) begin
                        stable <= sync;
                        cnt <= 12'h000;
                    end else begin
                        cnt <= cnt + 12'h001;
                    end
                end
            end
            assign db[gi] = stable;
        end
    endgenerate

    // Command-addressed parameters; a restore overrides a write in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            operation <= DEF_OPERATION;
            chg_v <= DEF_CHG_V;
            chg_i <= DEF_CHG_I;
            dis_v <= DEF_DIS_V;
            dis_i <= DEF_DIS_I;
            sys_cfg <= DEF_SYS_CFG;
            dir_cmd <= DEF_DIR_CMD;
            dir_mode <= DEF_DIR_MODE;
            restore_pass <= 1'b0;
        end else if (restore_pulse) begin
            operation <= DEF_OPERATION;
            chg_v <= DEF_CHG_V;
            chg_i <= DEF_CHG_I;
            dis_v <= DEF_DIS_V;
            dis_i <= DEF_DIS_I;
            dir_mode <= DEF_DIR_MODE;
            if (sys_cfg[SYS_CFG_NV_OFF_BIT] && !restore_pass) begin
                restore_pass <= 1'b1;
            end else begin
                sys_cfg <= DEF_SYS_CFG;
                restore_pass <= 1'b0;
            end
        end else if (cmd_valid && cmd.write) begin
            if (cmd.code == CODE_OPERATION) begin
                operation <= cmd.data[7:0];
            end else if (cmd.code == CODE_CHG_V) begin
                chg_v <= cmd.data;
            end else if (cmd.code == CODE_CHG_I) begin
                chg_i <= cmd.data;
            end else if (cmd.code == CODE_DIS_V) begin
                dis_v <= cmd.data;
            end else if (cmd.code == CODE_DIS_I) begin
                dis_i <= cmd.data;
            end else if (cmd.code == CODE_SYS_CFG) begin
                sys_cfg <= cmd.data;
            end else if (cmd.code == CODE_DIR_CMD) begin
                dir_cmd <= cmd.data[7:0];
            end else if (cmd.code == CODE_DIR_MODE) begin
                dir_mode <= cmd.data;
            end
        end
    end

    // Read answers; writes produce no answer
    always_comb begin
        next_resp = '{err: 1'b0, code: cmd.code, data: 16'h0000};
        if (cmd.code == CODE_OPERATION) begin
            next_resp.data = {8'h00, operation};
        end else if (cmd.code == CODE_CHG_V) begin
            next_resp.data = chg_v;
        end else if (cmd.code == CODE_CHG_I) begin
            next_resp.data = chg_i;
        end else if (cmd.code == CODE_DIS_V) begin
            next_resp.data = dis_v;
        end else if (cmd.code == CODE_DIS_I) begin
            next_resp.data = dis_i;
        end else if (cmd.code == CODE_SYS_CFG) begin
            next_resp.data = sys_cfg;
        end else if (cmd.code == CODE_DIR_CMD) begin
            next_resp.data = {8'h00, dir_cmd};
        end else if (cmd.code == CODE_DIR_MODE) begin
            next_resp.data = dir_mode;
        end else if (cmd.code == CODE_STATUS) begin
            next_resp.data = {8'h00, battery_mode, dir_discharge, current_limited,
                shutdown, fault_out, conv_enable, master, restore_pass};
        end else begin
            next_resp.err = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resp_valid <= 1'b0;
            resp <= '0;
        end else begin
            resp_valid <= cmd_valid && !cmd.write;
            if (cmd_valid && !cmd.write) begin
                resp <= next_resp;
            end
        end
    end

    // Mode is only taken from the stored selection at a power cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            battery_mode <= 1'b0;
        end else if (power_cycle) begin
            battery_mode <= HAS_FIELD_BUS && (dir_mode == DIR_MODE_BATTERY);
        end
    end

    // Direction and targets
    always_comb begin
        if (sys_cfg[SYS_CFG_BUS_DIR_BIT]) begin
            req_dis = (dir_cmd == DIR_CMD_DISCHARGE);
        end else begin
            req_dis = !db[IN_CD];
        end
        next_dir = dir_discharge;
        next_lim = 1'b0;
        if (!battery_mode) begin
            if (target_voltage > dc_voltage) begin
                next_dir = 1'b0;
            end else if (target_voltage < dc_voltage) begin
                next_dir = 1'b1;
            end
        end else if (!req_dis) begin
            next_dir = dc_voltage > chg_v;
            next_lim = dc_voltage > chg_v;
        end else begin
            next_dir = !(dc_voltage < dis_v);
            next_lim = dc_voltage < dis_v;
        end
        if (!battery_mode) begin
            next_vt = target_voltage;
        end else if (next_dir) begin
            next_vt = dis_v;
        end else begin
            next_vt = chg_v;
        end
        if (next_lim) begin
            next_it = LIMITED_CURRENT;
        end else if (next_dir) begin
            next_it = dis_i;
        end else begin
            next_it = chg_i;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dir_discharge <= 1'b0;
            current_limited <= 1'b0;
            voltage_target <= 16'h0000;
            current_target <= 16'h0000;
        end else begin
            dir_discharge <= next_dir;
            current_limited <= next_lim;
            voltage_target <= next_vt;
            current_target <= next_it;
        end
    end

    // Fault output and shutdown; cleared only by a power cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fault_out <= 1'b0;
            shutdown <= 1'b0;
            lead_busy <= 1'b0;
            lead_cnt <= 32'h0000_0000;
        end else if (power_cycle) begin
            fault_out <= 1'b0;
            shutdown <= 1'b0;
            lead_busy <= 1'b0;
            lead_cnt <= 32'h0000_0000;
        end else if (prot.grid_loss_event && !shutdown) begin
            fault_out <= 1'b1;
            shutdown <= 1'b1;
            lead_busy <= 1'b0;
        end else if (lead_busy) begin
            if (lead_cnt == FAULT_LEAD_CYCLES - 32'h0000_0001) begin
                shutdown <= 1'b1;
                lead_busy <= 1'b0;
            end else begin
                lead_cnt <= lead_cnt + 32'h0000_0001;
            end
        end else if (prot_lead && !shutdown) begin
            fault_out <= 1'b1;
            lead_busy <= 1'b1;
            lead_cnt <= 32'h0000_0000;
        end
    end

    // Output enable, current sharing and master selection
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_enable <= 1'b0;
            master <= 1'b0;
            parallel_ok <= 1'b0;
        end else begin
            conv_enable <= db[IN_REMOTE] && operation[OPERATION_ON_BIT] && !shutdown;
            master <= conv_enable && (voltage_target >= peer_max_voltage);
            parallel_ok <= (unit_count != 4'h0) && (unit_count <= MAX_UNITS);
        end
    end

    // Factory restore sequence, watched only in the window after power-up
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rs_state <= RS_ARM;
            win_cnt <= 32'h0000_0000;
            restore_pulse <= 1'b0;
        end else if (power_cycle) begin
            rs_state <= RS_ARM;
            win_cnt <= 32'h0000_0000;
            restore_pulse <= 1'b0;
        end else begin
            restore_pulse <= 1'b0;
            if (win_cnt != RESTORE_WINDOW_CYCLES) begin
                win_cnt <= win_cnt + 32'h0000_0001;
            end
            case (rs_state)
                RS_ARM: begin
                    if (win_cnt == SETTLE_CYC) begin
                        if (!db[IN_REMOTE] && addr_all_on) begin
                            rs_state <= RS_WAIT_OFF;
                        end else begin
                            rs_state <= RS_DONE;
                        end
                    end
                end
                RS_WAIT_OFF: begin
                    if (win_cnt == RESTORE_WINDOW_CYCLES) begin
                        rs_state <= RS_DONE;
                    end else if (addr_all_off) begin
                        rs_state <= RS_WAIT_ON;
                    end
                end
                RS_WAIT_ON: begin
                    if (win_cnt == RESTORE_WINDOW_CYCLES) begin
                        rs_state <= RS_DONE;
                    end else if (addr_all_on) begin
                        restore_pulse <= 1'b1;
                        rs_state <= RS_BLINK;
                    end
                end
                RS_BLINK: begin
                    if (blink_edges == BLINK_EDGES) begin
                        rs_state <= RS_DONE;
                    end
                end
                RS_DONE: begin
                    rs_state <= RS_DONE;
                end
                default: begin
                    rs_state <= RS_DONE;
                end
            endcase
        end
    end

    // Three green blinks after a restore
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            blink_cnt <= 32'h0000_0000;
            blink_edges <= 3'h0;
            blink_led <= 1'b0;
        end else if (rs_state != RS_BLINK) begin
            blink_cnt <= 32'h0000_0000;
            blink_edges <= 3'h0;
            blink_led <= restore_pulse;
        end else if (blink_edges != BLINK_EDGES) begin
            if (blink_cnt == BLINK_HALF_CYCLES - 32'h0000_0001) begin
                blink_cnt <= 32'h0000_0000;
                blink_edges <= blink_edges + 3'h1;
                blink_led <= !blink_led;
            end else begin
                blink_cnt <= blink_cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            green_led <= 1'b0;
        end else if (rs_state == RS_BLINK || restore_pulse) begin
            green_led <= blink_led && (blink_edges != BLINK_EDGES);
        end else begin
            green_led <= conv_enable;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    auto_charge_a: assert property (
        !battery_mode && !power_cycle && target_voltage > dc_voltage |=> !dir_discharge)
        else $error("auto mode did not charge");
    auto_discharge_a: assert property (
        !battery_mode && !power_cycle && target_voltage < dc_voltage |=> dir_discharge)
        else $error("auto mode did not discharge");
    bus_direction_a: assert property (
        battery_mode && !power_cycle && sys_cfg[SYS_CFG_BUS_DIR_BIT]
        && dir_cmd == DIR_CMD_DISCHARGE && dc_voltage >= dis_v
        |=> dir_discharge && !current_limited && voltage_target == $past(dis_v))
        else $error("bus discharge command not followed");
    pin_direction_a: assert property (
        battery_mode && !power_cycle && !sys_cfg[SYS_CFG_BUS_DIR_BIT] && db[IN_CD]
        && dc_voltage <= chg_v |=> !dir_discharge && current_target == $past(chg_i))
        else $error("pin charge request not followed");
    charge_fallback_a: assert property (
        battery_mode && !power_cycle && !req_dis && dc_voltage > chg_v
        |=> dir_discharge && current_target == LIMITED_CURRENT)
        else $error("charge fallback missing");
    fault_lead_a: assert property (
        prot_lead && !prot.grid_loss_event && !shutdown && !lead_busy && !power_cycle
        |=> fault_out && !shutdown ##0 (!shutdown)[*8])
        else $error("shutdown came without fault lead");
    fault_lead_end_a: assert property (
        $rose(shutdown) && !$past(prot.grid_loss_event)
        |-> $past(lead_cnt) == FAULT_LEAD_CYCLES - 32'h0000_0001)
        else $error("shutdown lead time wrong");
    grid_loss_a: assert property (
        prot.grid_loss_event && !shutdown && !power_cycle |=> shutdown && fault_out)
        else $error("grid loss did not shut down with fault");
    remote_off_a: assert property (
        !db[IN_REMOTE] |=> !conv_enable)
        else $error("output enabled with remote open");

endmodule

// >>> hw/bmc_pkg.sv
// Command codes, field layouts, reset defaults and timing for the mode controller.
package bmc_pkg;

    // Field-bus command codes
    localparam logic [15:0] CODE_OPERATION = 16'h0000;
    localparam logic [15:0] CODE_CHG_V = 16'h0020;
    localparam logic [15:0] CODE_CHG_I = 16'h0030;
    localparam logic [15:0] CODE_STATUS = 16'h0040;
    localparam logic [15:0] CODE_SYS_CFG = 16'h00C2;
    localparam logic [15:0] CODE_DIR_CMD = 16'h0100;
    localparam logic [15:0] CODE_DIS_V = 16'h0120;
    localparam logic [15:0] CODE_DIS_I = 16'h0130;
    localparam logic [15:0] CODE_DIR_MODE = 16'h0140;

    // Field positions and values
    localparam int SYS_CFG_BUS_DIR_BIT = 0;
    localparam int SYS_CFG_NV_OFF_BIT = 10;
    localparam int OPERATION_ON_BIT = 0;
    localparam logic [15:0] DIR_MODE_BATTERY = 16'h0001;
    localparam logic [7:0] DIR_CMD_DISCHARGE = 8'h01;

    // Reset defaults; the factory-restore sequence restores all of them except DEF_DIR_CMD, and DEF_SYS_CFG only every second pass while storage is disabled
    localparam logic [7:0] DEF_OPERATION = 8'h01;
    localparam logic [15:0] DEF_CHG_V = 16'h1388;
    localparam logic [15:0] DEF_CHG_I = 16'h07D0;
    localparam logic [15:0] DEF_DIS_V = 16'h1194;
    localparam logic [15:0] DEF_DIS_I = 16'h07D0;
    localparam logic [15:0] DEF_SYS_CFG = 16'h0000;
    localparam logic [7:0] DEF_DIR_CMD = 8'h00;
    localparam logic [15:0] DEF_DIR_MODE = 16'h0000;

    // Reduced current while the requested direction cannot be held
    localparam logic [15:0] RATED_CURRENT = 16'h0BB8;
    localparam int LIMIT_PERCENT = 5;
    localparam logic [15:0] LIMITED_CURRENT = 16'(int'(RATED_CURRENT) * LIMIT_PERCENT / 100);

    // Parallel operation
    localparam logic [3:0] MAX_UNITS = 4'h9;

    // Timing
    localparam longint CLK_HZ = 250_000_000;
    localparam longint FAULT_LEAD_MS = 100;
    localparam longint RESTORE_WINDOW_S = 15;
    localparam longint BLINK_HALF_MS = 250;
    localparam longint DEBOUNCE_US = 10;
    localparam logic [31:0] FAULT_LEAD_CYC = 32'(FAULT_LEAD_MS * CLK_HZ / 1000);
    localparam logic [31:0] RESTORE_WINDOW_CYC = 32'(RESTORE_WINDOW_S * CLK_HZ);
    localparam logic [31:0] BLINK_HALF_CYC = 32'(BLINK_HALF_MS * CLK_HZ / 1000);
    localparam logic [11:0] DEBOUNCE_CYC = 12'(DEBOUNCE_US * CLK_HZ / 1_000_000);
    localparam logic [31:0] SETTLE_CYC = 32'(2 * DEBOUNCE_US * CLK_HZ / 1_000_000 + 8);
    localparam logic [2:0] BLINK_EDGES = 3'h6;

    // Pin inputs that pass the synchroniser and debouncer
    localparam int NUM_IN = 5;
    localparam int IN_CD = 0;
    localparam int IN_REMOTE = 1;
    localparam int IN_ADDR = 2;
    localparam int ADDR_BITS = 3;

    typedef struct packed {
        logic write;
        logic [15:0] code;
        logic [15:0] data;
    } bmc_cmd_t;

    typedef struct packed {
        logic err;
        logic [15:0] code;
        logic [15:0] data;
    } bmc_resp_t;

    typedef struct packed {
        logic overload_protection;
        logic short_circuit_protection;
        logic over_temperature;
        logic grid_loss_event;
    } bmc_prot_t;

endpackage
